// >>> rtl/jtdr_edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module jtdr_edge_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic prev;
	logic next_meta;
	logic next_sync;
	logic next_prev;

	// Next values; only sync and prev are looked at past the first flop
	always_comb begin
		next_meta = din;
		next_sync = meta;
		next_prev = sync;
	end

	// Freeze while the clock enable is low
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= 1'h0;
			sync <= 1'h0;
			prev <= 1'h0;
		end else if (ce) begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
		end
	end

	// Edge pulses last one enabled cycle
	assign level = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule : jtdr_edge_sync

// >>> rtl/jtdr_params.svh
// Constants for the boundary-scan test data registers
`ifndef JTDR_PARAMS_SVH
`define JTDR_PARAMS_SVH
// Instruction width and codes
`define JTDR_IR_W 3
`define JTDR_IR_EXTEST 3'h0
`define JTDR_IR_IDCODE 3'h1
`define JTDR_IR_SAMPLE 3'h2
`define JTDR_IR_CLAMP 3'h3
`define JTDR_IR_HIGHZ 3'h4
`define JTDR_IR_BYPASS 3'h7
// Identification word layout
`define JTDR_ID_W 32
`define JTDR_ID_REV_LSB 28
`define JTDR_ID_DEV_LSB 12
`define JTDR_ID_MFR_LSB 1
`define JTDR_ID_MARK_BIT 0
`define JTDR_ID_MARK 1'h1
// Default boundary chain length
`define JTDR_BSR_LEN 8
// Reset values
`define JTDR_BYP_RST 1'h0
`endif

// >>> rtl/jtdr_pkg.sv
// Types shared by the test data register block
package jtdr_pkg;
	// Tap state codes supplied by the neighbouring controller
	typedef enum logic [3:0] {
		JTDR_TLR = 4'h0,
		JTDR_RTI = 4'h1,
		JTDR_SEL_DR = 4'h2,
		JTDR_CAP_DR = 4'h3,
		JTDR_SHF_DR = 4'h4,
		JTDR_EX1_DR = 4'h5,
		JTDR_PAU_DR = 4'h6,
		JTDR_EX2_DR = 4'h7,
		JTDR_UPD_DR = 4'h8,
		JTDR_SEL_IR = 4'h9,
		JTDR_CAP_IR = 4'hA,
		JTDR_SHF_IR = 4'hB,
		JTDR_EX1_IR = 4'hC,
		JTDR_PAU_IR = 4'hD,
		JTDR_EX2_IR = 4'hE,
		JTDR_UPD_IR = 4'hF
	} jtdr_tap_t;
	// Register chosen for the serial path
	typedef enum logic [1:0] {
		JTDR_SEL_BYP = 2'h0,
		JTDR_SEL_BSR = 2'h1,
		JTDR_SEL_IDR = 2'h2
	} jtdr_sel_t;
	// Controller view handed in with the instruction
	typedef struct packed {
		jtdr_tap_t state;
		logic [2:0] instr;
	} jtdr_ctl_t;
endpackage : jtdr_pkg

// >>> rtl/jtdr_test_data_regs.sv
// Bypass, boundary scan and identification registers behind the test port
// Operation
// - Bypass register is one bit, a short path from serial in to out.
// - Bypass is in the path for BYPASS, CLAMP and HIGHZ.
// - Boundary register: shift path plus separately latched parallel output.
// - Identification register: 32-bit shift stage with 32-bit latched output.
// - Identification register selected for IDCODE and in logic-reset state.
// - Fixed identity word: revision, device code, maker code, mark bit one.
// - Instructions are three bits: BYPASS 111, IDCODE 001, HIGHZ 100, CLAMP 011.
// - Capture state loads the identity word into the selected identification register.
// - Shift state moves only the selected register one stage per rising edge.
`timescale 1ns/10ps
`include "jtdr_params.svh"
module jtdr_test_data_regs #(
	parameter int BSR_LEN = `JTDR_BSR_LEN,
	parameter logic [3:0] ID_REV = 4'h0, // Arbitrary value
	parameter logic [15:0] ID_DEV = 16'h1234, // Arbitrary value
	parameter logic [10:0] ID_MFR = 11'h055 // Arbitrary value
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic test_clock_pin,
	input wire logic test_serial_in,
	input wire jtdr_pkg::jtdr_ctl_t ctl,
	input wire logic [BSR_LEN-1:0] bsr_capture,
	output logic test_serial_out,
	output logic [BSR_LEN-1:0] bsr_parallel,
	output logic [`JTDR_ID_W-1:0] id_parallel,
	output logic outputs_highz,
	output logic outputs_from_bsr
);
	// ********************************
	// Checks
	// ********************************
	// The shift stage slices one bit off the bottom, so a single-cell chain cannot work
	if (BSR_LEN < 2) begin : g_bad_len
		$error("BSR_LEN must be at least 2");
	end

	// Field widths must tile the identity word with the mark bit at the bottom
	if ((`JTDR_ID_REV_LSB + $bits(ID_REV) != `JTDR_ID_W) ||
			(`JTDR_ID_DEV_LSB + $bits(ID_DEV) != `JTDR_ID_REV_LSB) ||
			(`JTDR_ID_MFR_LSB + $bits(ID_MFR) != `JTDR_ID_DEV_LSB) ||
			(`JTDR_ID_MARK_BIT + 1 != `JTDR_ID_MFR_LSB)) begin : g_bad_id
		$error("identity fields do not fill the word");
	end

	// Mark bit at the bottom so it leaves first on the serial out
	localparam logic [`JTDR_ID_W-1:0] ID_WORD = {ID_REV, ID_DEV, ID_MFR, `JTDR_ID_MARK};

	// ********************************
	// Pin sampling
	// ********************************
	// Limitation: the test clock must stay high and low for at least three system clocks,
	// since each edge needs two synchroniser flops and one compare before it is seen
	logic tck_rise;
	logic tck_fall;
	logic tdi_lvl;

	jtdr_edge_sync u_tck (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.din(test_clock_pin),
		.level(),
		.rise(tck_rise),
		.fall(tck_fall)
	);

	// Data sampled with the same latency as the clock, so it lines up at the edge
	jtdr_edge_sync u_tdi (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.din(test_serial_in),
		.level(tdi_lvl),
		.rise(),
		.fall()
	);

	// ********************************
	// Selection
	// ********************************
	// Decodes the instruction; used for path and serial out selection, not for pin control
	// Logic-reset acts as an identity read, so a freshly reset tester sees the identity first
	function automatic jtdr_pkg::jtdr_sel_t sel_of(input jtdr_pkg::jtdr_ctl_t c);
		if (c.state == jtdr_pkg::JTDR_TLR) begin
			sel_of = jtdr_pkg::JTDR_SEL_IDR;
		end else begin
			case (c.instr)
				`JTDR_IR_IDCODE: sel_of = jtdr_pkg::JTDR_SEL_IDR;
				`JTDR_IR_EXTEST,
				`JTDR_IR_SAMPLE: sel_of = jtdr_pkg::JTDR_SEL_BSR;
				`JTDR_IR_BYPASS,
				`JTDR_IR_CLAMP,
				`JTDR_IR_HIGHZ: sel_of = jtdr_pkg::JTDR_SEL_BYP;
				default: sel_of = jtdr_pkg::JTDR_SEL_BYP;
			endcase
		end
	endfunction : sel_of

	jtdr_pkg::jtdr_sel_t sel;
	logic cap;
	logic shf;
	logic upd;
	assign sel = sel_of(ctl);
	// Capture and shift act on the detected rise, with the controller state of that cycle
	assign cap = tck_rise && (ctl.state == jtdr_pkg::JTDR_CAP_DR);
	assign shf = tck_rise && (ctl.state == jtdr_pkg::JTDR_SHF_DR);
	// Parallel latches load on the falling test clock edge in update
	assign upd = tck_fall && (ctl.state == jtdr_pkg::JTDR_UPD_DR);

	// ********************************
	// Shift stages
	// ********************************
	logic byp;
	logic [BSR_LEN-1:0] bsr_sh;
	logic [`JTDR_ID_W-1:0] id_sh;
	logic next_byp;
	logic [BSR_LEN-1:0] next_bsr_sh;
	logic [`JTDR_ID_W-1:0] next_id_sh;
	logic [BSR_LEN-1:0] next_bsr_parallel;
	logic [`JTDR_ID_W-1:0] next_id_parallel;
	logic next_tdo;

	// Capture and shift; unselected registers hold
	// Latches copy the shift stage only in update, so the parallel side never ripples while shifting
	always_comb begin
		next_byp = byp;
		next_bsr_sh = bsr_sh;
		next_id_sh = id_sh;
		next_bsr_parallel = bsr_parallel;
		next_id_parallel = id_parallel;
		next_tdo = test_serial_out;
		case (sel)
			jtdr_pkg::JTDR_SEL_BYP: begin
				if (cap) begin
					next_byp = 1'h0;
				end else if (shf) begin
					next_byp = tdi_lvl;
				end
			end
			jtdr_pkg::JTDR_SEL_BSR: begin
				if (cap) begin
					next_bsr_sh = bsr_capture;
				end else if (shf) begin
					next_bsr_sh = {tdi_lvl, bsr_sh[BSR_LEN-1:1]};
				end
				if (upd) begin
					next_bsr_parallel = bsr_sh;
				end
			end
			jtdr_pkg::JTDR_SEL_IDR: begin
				if (cap) begin
					next_id_sh = ID_WORD;
				end else if (shf) begin
					next_id_sh = {tdi_lvl, id_sh[`JTDR_ID_W-1:1]};
				end
				if (upd) begin
					next_id_parallel = id_sh;
				end
			end
			default: begin
				next_byp = byp;
			end
		endcase
		// Output changes on the falling edge, stable for the tester's rising sample
		if (tck_fall) begin
			case (sel)
				jtdr_pkg::JTDR_SEL_BYP: next_tdo = byp;
				jtdr_pkg::JTDR_SEL_BSR: next_tdo = bsr_sh[0];
				jtdr_pkg::JTDR_SEL_IDR: next_tdo = id_sh[0];
				default: next_tdo = byp;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (srst) begin
			byp <= `JTDR_BYP_RST;
			bsr_sh <= '0;
			id_sh <= '0;
			bsr_parallel <= '0;
			id_parallel <= '0;
			test_serial_out <= 1'h0;
		end else if (ce) begin
			byp <= next_byp;
			bsr_sh <= next_bsr_sh;
			id_sh <= next_id_sh;
			bsr_parallel <= next_bsr_parallel;
			id_parallel <= next_id_parallel;
			test_serial_out <= next_tdo;
		end
	end

	// ********************************
	// Output pin control
	// ********************************
	logic next_highz;
	logic next_from_bsr;

	// Flags are registered, so pin control follows an instruction change one cycle late
	// Reset state returns pins to normal operation
	always_comb begin
		next_highz = (ctl.state != jtdr_pkg::JTDR_TLR) && (ctl.instr == `JTDR_IR_HIGHZ);
		next_from_bsr = (ctl.state != jtdr_pkg::JTDR_TLR) &&
			((ctl.instr == `JTDR_IR_EXTEST) || (ctl.instr == `JTDR_IR_CLAMP));
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (srst) begin
			outputs_highz <= 1'h0;
			outputs_from_bsr <= 1'h0;
		end else if (ce) begin
			outputs_highz <= next_highz;
			outputs_from_bsr <= next_from_bsr;
		end
	end
endmodule : jtdr_test_data_regs

// >>> testbench/jtdr_monitor.sv
// Assertions on the test data register ports
`timescale 1ns/10ps
module jtdr_monitor #(
	parameter int BSR_LEN = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic test_clock_pin,
	input wire logic test_serial_in,
	input wire jtdr_pkg::jtdr_ctl_t ctl,
	input wire logic test_serial_out,
	input wire logic [BSR_LEN-1:0] bsr_parallel,
	input wire logic [31:0] id_parallel,
	input wire logic outputs_highz,
	input wire logic outputs_from_bsr
);
	// *****
	// Properties
	// *****
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Decoded controller view, shared by several checks
	wire logic cap = ctl.state == jtdr_pkg::JTDR_CAP_DR;
	wire logic tlr = ctl.state == jtdr_pkg::JTDR_TLR;
	wire logic upd = ctl.state == jtdr_pkg::JTDR_UPD_DR;
	property p_out_edge; !$stable(test_serial_out) |->
		($past(test_clock_pin, 3) && !$past(test_clock_pin, 2)) || ($past(test_clock_pin, 4) && !$past(test_clock_pin, 3)) ||
		($past(test_clock_pin, 5) && !$past(test_clock_pin, 4)) || ($past(test_clock_pin, 6) && !$past(test_clock_pin, 5));
		endproperty
	property p_byp_cap; $fell(test_clock_pin) && cap && ctl.instr == 3'h7 |-> ##6 !test_serial_out; endproperty
	property p_id_mark; $fell(test_clock_pin) && cap && ctl.instr == 3'h1 |-> ##6 test_serial_out; endproperty
	property p_byp_shf; $fell(test_clock_pin) && ctl.state == jtdr_pkg::JTDR_SHF_DR && ctl.instr inside {3'h7, 3'h3, 3'h4}
		|-> ##6 test_serial_out == $past(test_serial_in, 6); endproperty
	// Flags are frozen while the clock enable is low
	property p_highz; !$past(srst) && $past(ce) |-> outputs_highz == ($past(ctl.instr) == 3'h4 && !$past(tlr)); endproperty
	property p_from_bsr; !$past(srst) && $past(ce) |->
		outputs_from_bsr == ($past(ctl.instr) inside {3'h0, 3'h3} && !$past(tlr)); endproperty
	// Latches move only on a fall in the update state, never during shifting
	property p_id_hold; !$stable(id_parallel) |-> $past(upd, 2); endproperty
	property p_bsr_hold; !$stable(bsr_parallel) |-> $past(upd, 2); endproperty
	a_out_edge: assert property (p_out_edge) else $error("serial out moved off a fall");
	a_byp_cap: assert property (p_byp_cap) else $error("bypass capture not zero");
	a_id_mark: assert property (p_id_mark) else $error("identity mark bit not first");
	a_byp_shf: assert property (p_byp_shf) else $error("bypass path wrong");
	a_highz: assert property (p_highz) else $error("float flag wrong");
	a_from_bsr: assert property (p_from_bsr) else $error("boundary drive flag wrong");
	a_id_hold: assert property (p_id_hold) else $error("identity latch moved early");
	a_bsr_hold: assert property (p_bsr_hold) else $error("boundary latch moved early");
	c_id: cover property ($fell(test_clock_pin) && upd && ctl.instr == 3'h1);
	c_float: cover property (outputs_highz);
	c_bsr: cover property (!$stable(bsr_parallel));
endmodule : jtdr_monitor
bind jtdr_test_data_regs jtdr_monitor #(.BSR_LEN(BSR_LEN)) i_jtdr_monitor (.*);

// >>> testbench/jtdr_tester.sv
// Stand-in boundary-scan tester with the controller state it commands
`timescale 1ns/10ps
module jtdr_tester (
	input wire logic clk,
	input wire logic test_serial_out,
	output logic test_clock_pin,
	output logic test_serial_in,
	output jtdr_pkg::jtdr_ctl_t ctl
);
	// *****
	// Pulse engine
	// *****
	// Test clock rests low between frames
	initial begin
		test_clock_pin = 1'h0;
		test_serial_in = 1'h0;
		ctl = {jtdr_pkg::JTDR_TLR, 3'h1};
	end
	// One 80 ns pulse; out bit read mid-high, after the last fall settled
	task automatic pulse(input jtdr_pkg::jtdr_tap_t st, input logic [2:0] ir, input logic din, output logic dout);
		ctl <= {st, ir};
		test_serial_in <= din;
		test_clock_pin <= 1'h1;
		repeat (2) @(posedge clk);
		dout = test_serial_out;
		repeat (2) @(posedge clk);
		test_clock_pin <= 1'h0;
		repeat (3) @(posedge clk);
		test_serial_in <= ~din; // Stale data shown inverted, never held
		@(posedge clk);
	endtask : pulse
endmodule : jtdr_tester

// >>> testbench/tb_jtdr_test_data_regs.sv
// Self-checking bench for the test data registers
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t: %h not %h", $time, a, e); end end
module tb_jtdr_test_data_regs;
	// *****
	// Instances
	// *****
	localparam logic [31:0] ID = {4'h5, 16'hA5C3, 11'h2B1, 1'h1}; // Arbitrary fields
	localparam logic [31:0] PAT = 32'h3CA50F96;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic ce = 1'h1;
	logic [7:0] bcap = 8'h5A;
	logic tck, tdi, tdo, highz, fbsr;
	jtdr_pkg::jtdr_ctl_t ctl;
	logic [7:0] bpar;
	logic [31:0] idpar;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	jtdr_test_data_regs #(.BSR_LEN(8), .ID_REV(ID[31:28]), .ID_DEV(ID[27:12]), .ID_MFR(ID[11:1])) i_jtdr_test_data_regs (
		.clk(clk), .srst(srst), .ce(ce), .test_clock_pin(tck), .test_serial_in(tdi), .ctl(ctl), .bsr_capture(bcap),
		.test_serial_out(tdo), .bsr_parallel(bpar), .id_parallel(idpar), .outputs_highz(highz), .outputs_from_bsr(fbsr));
	jtdr_tester i_jtdr_tester (.clk(clk), .test_serial_out(tdo), .test_clock_pin(tck), .test_serial_in(tdi), .ctl(ctl));
	// Capture, shift n bits, update, then rest so the latch settles
	task automatic scan(input logic [2:0] ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = '0;
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_CAP_DR, ir, 1'h0, b);
		for (int k = 0; k < n; k++) begin
			i_jtdr_tester.pulse(jtdr_pkg::JTDR_SHF_DR, ir, din[k], b);
			dout[k] = b;
		end
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_UPD_DR, ir, 1'h0, b);
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_RTI, ir, 1'h0, b);
	endtask : scan
	// Identity word out first, new word latched
	task automatic t_idcode();
		logic [31:0] d;
		scan(3'h1, 32, PAT, d);
		`CHK(d, ID)
		`CHK(d[0], 1'h1)
		`CHK(idpar, PAT)
	endtask : t_idcode
	// One-bit path for each bypass code
	task automatic t_bypass();
		logic [31:0] d;
		logic [2:0] codes [3] = '{3'h7, 3'h3, 3'h4};
		foreach (codes[i]) begin
			scan(codes[i], 3, 32'h5, d);
			`CHK(d[2:0], 3'h2)
			`CHK(highz, codes[i] == 3'h4)
			`CHK(idpar, PAT)
		end
	endtask : t_bypass
	// Boundary chain sampled, shifted and latched
	task automatic t_bsr();
		logic [31:0] d;
		for (int i = 0; i < 3; i += 2) begin
			scan(3'(i), 8, 32'hC3 ^ 32'(i), d);
			`CHK(d[7:0], 8'h5A)
			`CHK(bpar, 8'hC3 ^ 8'(i))
			`CHK(fbsr, i == 0)
			`CHK(idpar, PAT)
		end
	endtask : t_bsr
	// Shift pulse while the clock enable is low leaves chain and serial out alone
	task automatic t_freeze();
		logic b;
		ce <= 1'h0;
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_SHF_DR, 3'h2, 1'h0, b);
		ce <= 1'h1;
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_RTI, 3'h2, 1'h0, b);
		`CHK(b, 1'h1)
	endtask : t_freeze
	// Logic-reset picks the identity path and releases the pins, with HIGHZ as the held instruction
	task automatic t_reset_state();
		logic b;
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_TLR, 3'h4, 1'h0, b);
		i_jtdr_tester.pulse(jtdr_pkg::JTDR_TLR, 3'h4, 1'h0, b);
		`CHK(b, PAT[0])
		`CHK(highz, 1'h0)
	endtask : t_reset_state
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	// Hang guard, far beyond the few hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		repeat (4) @(posedge clk);
		t_idcode();
		t_bypass();
		t_bsr();
		t_freeze();
		t_reset_state();
		test_done();
	end
endmodule : tb_jtdr_test_data_regs
